// ===== pmsr_pkg.sv
// pmsr_pkg: register map, field positions and reset values of the
// medium attachment status register subset.
// assumes: 16-bit management data and register address, 5-bit device address,
// delivered by the management access logic of the device core.
package pmsr_pkg;

    localparam logic [4:0]  PMSR_DEV_ADDR      = 5'h01;
    localparam logic [15:0] PMSR_CTRL2_ADDR    = 16'h0007;
    localparam logic [15:0] PMSR_STAT2_ADDR    = 16'h0008;
    localparam logic [15:0] PMSR_TXDIS_ADDR    = 16'h0009;
    localparam logic [15:0] PMSR_EXTAB_ADDR    = 16'h000B;

    // second status register fields
    localparam int          PMSR_PRESENT_LSB   = 14;
    localparam logic [1:0]  PMSR_PRESENT_CODE  = 2'h2;
    localparam int          PMSR_EXT_ABLE_BIT  = 9;
    localparam int          PMSR_TXGATE_BIT    = 8;
    localparam int          PMSR_LOOPBACK_BIT  = 0;
    localparam logic [15:0] PMSR_STAT2_RESET   = 16'h8301;

    // transmit-disable register
    localparam int          PMSR_TXOFF_BIT     = 0;
    localparam logic        PMSR_TXOFF_RESET   = 1'b0;

    // extended abilities register
    localparam int          PMSR_BT1_ABLE_BIT  = 11;
    localparam logic [15:0] PMSR_EXTAB_RESET   = 16'h0800;

    // medium type selection field
    localparam int          PMSR_TYPE_W        = 7;
    localparam logic [6:0]  PMSR_TYPE_RESET    = 7'h3D;

    // source of the medium type applied to the link
    typedef enum logic [1:0] {
        PMSR_LINK_AUTONEG = 2'b00,
        PMSR_LINK_FORCED  = 2'b01
    } pmsr_link_mode_t;

endpackage : pmsr_pkg

// ===== pmsr_regs.sv
// pmsr_regs: medium attachment status, transmit-disable, extended ability
// and medium type selection registers of management device 0x01.
// assumes: the management access logic gives a one-cycle write strobe and
// a read select with address; read data is registered, valid next cycle.
// the medium type selection field is kept at register 0x0007 of this bank.
`timescale 1ns/1ps

module pmsr_regs
    import pmsr_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // management access
    input  wire logic [4:0]  mgmt_dev_addr,
    input  wire logic [15:0] mgmt_reg_addr,
    input  wire logic        mgmt_wr,
    input  wire logic        mgmt_rd,
    input  wire logic [15:0] mgmt_wdata,
    output logic [15:0]      mgmt_rdata,
    output logic             mgmt_ack,
    // link configuration from the core
    input  wire logic        autoneg_enable,
    input  wire logic        forced_link_enable,
    input  wire logic [6:0]  autoneg_type,
    // transmit path
    input  wire logic        tx_data_in,
    output logic             tx_line_out,
    output logic             transmit_output_off,
    output logic [6:0]       active_medium_type
);

    ////////////////////////////////////////////////////////////////////////
    // decode
    // a foreign device address selects nothing, so such accesses fall
    // through to a zero read and a dropped write
    wire dev_hit   = (mgmt_dev_addr == PMSR_DEV_ADDR);
    wire sel_ctrl2 = dev_hit && (mgmt_reg_addr == PMSR_CTRL2_ADDR);
    wire sel_stat2 = dev_hit && (mgmt_reg_addr == PMSR_STAT2_ADDR);
    wire sel_txdis = dev_hit && (mgmt_reg_addr == PMSR_TXDIS_ADDR);
    wire sel_extab = dev_hit && (mgmt_reg_addr == PMSR_EXTAB_ADDR);

    ////////////////////////////////////////////////////////////////////////
    // writable state
    logic       txoff_q;
    logic [6:0] type_sel_q;
    logic [15:0] rdata_q;
    logic        ack_q;

    // only the documented writable bits store; the rest are dropped
    // the type field is kept while autoneg owns the link, so a later
    // switch to forced mode picks it up at once
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txoff_q    <= PMSR_TXOFF_RESET;
            type_sel_q <= PMSR_TYPE_RESET;
        end else if (mgmt_wr) begin
            if (sel_txdis)
                txoff_q <= mgmt_wdata[PMSR_TXOFF_BIT];
            if (sel_ctrl2)
                type_sel_q <= mgmt_wdata[PMSR_TYPE_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // constant words
    logic [15:0] stat2_word;
    logic [15:0] extab_word;

    // second status: presence code 10, extended ability, transmit gate and
    // loopback bits set, reserved bits zero; a constant, so no write can
    // ever clear an ability bit
    pmsr_ro_word #(.VALUE(PMSR_STAT2_RESET)) u_stat2 (
        .sel   (sel_stat2),
        .rdata (stat2_word)
    );

    pmsr_ro_word #(.VALUE(PMSR_EXTAB_RESET)) u_extab (
        .sel   (sel_extab),
        .rdata (extab_word)
    );

    // read mux; unmapped addresses return zero
    // or-combining is safe because at most one select is high at a time
    wire [15:0] txdis_word = sel_txdis ? {15'h0000, txoff_q} : 16'h0000;
    wire [15:0] ctrl2_word = sel_ctrl2 ? {9'h000, type_sel_q} : 16'h0000;
    wire [15:0] rd_mux     = stat2_word | extab_word | txdis_word | ctrl2_word;

    // registered read data, one cycle after the select
    // ack answers writes too, so software can pace either kind of access
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= 16'h0000;
            ack_q   <= 1'b0;
        end else begin
            ack_q   <= mgmt_rd | mgmt_wr;
            if (mgmt_rd)
                rdata_q <= rd_mux;
        end
    end

    assign mgmt_rdata = rdata_q;
    assign mgmt_ack   = ack_q;

    ////////////////////////////////////////////////////////////////////////
    // transmit gate and medium type
    // gating is combinational so a disable takes effect without a lag
    // limitation: the gate only holds the line low; the core keeps sending
    assign transmit_output_off = txoff_q;
    assign tx_line_out         = tx_data_in & ~txoff_q;

    // forced selection only when autoneg is off and forcing is on
    pmsr_link_mode_t link_mode;
    assign link_mode = (!autoneg_enable && forced_link_enable) ?
                       PMSR_LINK_FORCED : PMSR_LINK_AUTONEG;
    assign active_medium_type = (link_mode == PMSR_LINK_FORCED) ?
                                type_sel_q : autoneg_type;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // all checks share the one clock and the synchronous reset; read checks
    // look one edge after the strobe, where the registered data stands
    sequence s_stat2_read;
        mgmt_rd && sel_stat2;
    endsequence

    sequence s_ctrl2_read;
        mgmt_rd && sel_ctrl2;
    endsequence

    sequence s_txoff_write;
        mgmt_wr && sel_txdis && mgmt_wdata[PMSR_TXOFF_BIT];
    endsequence

    sequence s_txon_write;
        mgmt_wr && sel_txdis && !mgmt_wdata[PMSR_TXOFF_BIT];
    endsequence

    sequence s_forced_cfg;
        !autoneg_enable && forced_link_enable;
    endsequence

    // fixed ability bits of the second status word
    a_stat2_present: assert property (@(posedge clock) disable iff (!rst_n)
        s_stat2_read |=> mgmt_rdata[15:14] == PMSR_PRESENT_CODE)
        else $error("presence code wrong");
    a_stat2_extable: assert property (@(posedge clock) disable iff (!rst_n)
        s_stat2_read |=> mgmt_rdata[PMSR_EXT_ABLE_BIT])
        else $error("extended ability bit clear");
    a_stat2_txgate: assert property (@(posedge clock) disable iff (!rst_n)
        s_stat2_read |=> mgmt_rdata[PMSR_TXGATE_BIT])
        else $error("transmit gate bit clear");
    a_stat2_loop: assert property (@(posedge clock) disable iff (!rst_n)
        s_stat2_read |=> mgmt_rdata[PMSR_LOOPBACK_BIT] && mgmt_rdata[7:1] == 7'h00)
        else $error("loopback bit or reserved wrong");
    a_stat2_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        s_stat2_read |=> mgmt_rdata[13:10] == 4'h0)
        else $error("status reserved bits not zero");

    // transmit gate; a later write may legally undo the disable, so set
    // and clear are checked one edge on and the hold separately
    a_txoff_gate: assert property (@(posedge clock) disable iff (!rst_n)
        s_txoff_write |=> !tx_line_out && transmit_output_off)
        else $error("line driven while disabled");
    a_txoff_clear: assert property (@(posedge clock) disable iff (!rst_n)
        s_txon_write |=> !transmit_output_off)
        else $error("transmit disable not cleared");
    a_txoff_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !(mgmt_wr && sel_txdis) |=> $stable(transmit_output_off))
        else $error("transmit disable changed without write");
    a_tx_follow: assert property (@(posedge clock) disable iff (!rst_n)
        !transmit_output_off |-> tx_line_out == tx_data_in)
        else $error("line not following data while enabled");
    a_txdis_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        mgmt_rd && sel_txdis |=> mgmt_rdata[15:1] == 15'h0000)
        else $error("reserved bits not zero");

    // extended abilities word
    a_extab_bt1: assert property (@(posedge clock) disable iff (!rst_n)
        mgmt_rd && sel_extab |=> mgmt_rdata == PMSR_EXTAB_RESET)
        else $error("extended ability word wrong");

    // medium type selection
    a_type_forced: assert property (@(posedge clock) disable iff (!rst_n)
        autoneg_enable |-> active_medium_type == autoneg_type)
        else $error("forced type used under autoneg");
    a_type_apply: assert property (@(posedge clock) disable iff (!rst_n)
        s_forced_cfg |-> active_medium_type == type_sel_q)
        else $error("forced type not applied");
    a_type_noforce: assert property (@(posedge clock) disable iff (!rst_n)
        !autoneg_enable && !forced_link_enable |-> active_medium_type == autoneg_type)
        else $error("type applied without forcing");
    a_ctrl2_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        s_ctrl2_read |=> mgmt_rdata[15:7] == 9'h000)
        else $error("type word reserved bits not zero");

    // decode and handshake
    a_other_dev: assert property (@(posedge clock) disable iff (!rst_n)
        mgmt_rd && mgmt_dev_addr != PMSR_DEV_ADDR |=> mgmt_rdata == 16'h0000)
        else $error("foreign device answered");
    a_unmapped_zero: assert property (@(posedge clock) disable iff (!rst_n)
        mgmt_rd && dev_hit && !(sel_stat2 || sel_txdis || sel_extab || sel_ctrl2)
        |=> mgmt_rdata == 16'h0000)
        else $error("unmapped register answered");
    a_ack_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        mgmt_rd || mgmt_wr |=> mgmt_ack)
        else $error("access not acknowledged");
    a_ack_idle: assert property (@(posedge clock) disable iff (!rst_n)
        !mgmt_rd && !mgmt_wr |=> !mgmt_ack)
        else $error("ack without access");
    a_rdata_hold: assert property (@(posedge clock) disable iff (!rst_n)
        !mgmt_rd |=> $stable(mgmt_rdata))
        else $error("read data changed without read");

endmodule : pmsr_regs

// ===== pmsr_regs_tb.sv
// pmsr_regs_tb: self-checking bench for the medium attachment register subset.
// assumes: one-cycle rd/wr strobes; ack and read data one cycle after a strobe.
`timescale 1ns/1ps
module pmsr_regs_tb;
    import pmsr_pkg::*;

    typedef struct {
        logic [4:0]  dev;
        logic [15:0] adr;
        logic [15:0] exp;
    } pmsr_row_t;

    // clock, reset and management stimulus
    logic        clock   = 1'b0;
    logic        rst_n   = 1'b0;
    logic [4:0]  dev     = 5'h01;
    logic [15:0] reg_a   = 16'h0000;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [15:0] wdata   = 16'h0000;
    logic        an_en   = 1'b1;
    logic        forced  = 1'b0;
    logic [6:0]  an_type = 7'h15;
    logic        tx_in   = 1'b1;
    logic [15:0] rdata;
    logic        ack;
    logic        tx_out;
    logic        off;
    logic [6:0]  act_type;
    int          num_errors = 0;
    int          cmp_count  = 0;
    int          cycles     = 0;
    // reads: other device and unmapped word must give zero
    pmsr_row_t   rows[6] = '{'{5'h01, 16'h0008, 16'h8301}, '{5'h01, 16'h000B, 16'h0800},
                             '{5'h01, 16'h0009, 16'h0000}, '{5'h01, 16'h0007, 16'h003D},
                             '{5'h02, 16'h0008, 16'h0000}, '{5'h01, 16'h000A, 16'h0000}};

    pmsr_regs pmsr_regs_inst (.clock(clock), .rst_n(rst_n), .mgmt_dev_addr(dev),
        .mgmt_reg_addr(reg_a), .mgmt_wr(wr), .mgmt_rd(rd), .mgmt_wdata(wdata),
        .mgmt_rdata(rdata), .mgmt_ack(ack), .autoneg_enable(an_en),
        .forced_link_enable(forced), .autoneg_type(an_type), .tx_data_in(tx_in),
        .tx_line_out(tx_out), .transmit_output_off(off), .active_medium_type(act_type));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard; a stuck bench must still reach the verdict
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            test_done();
        end
    end

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // one access, strobe held for exactly one rising edge
    task acc(input logic w, input logic [4:0] d, input logic [15:0] a, input logic [15:0] v);
        @(negedge clock);
        dev   = d;
        reg_a = a;
        wdata = v;
        wr    = w;
        rd    = ~w;
        @(negedge clock);
        wr = 1'b0;
        rd = 1'b0;
        chk("ack", 16'h0001, {15'h0000, ack});
    endtask : acc

    task test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    ////////////////////////////////////////////////////////////////////////////
    // table reads, then hand-written write, gating and reset cases
    initial begin
        repeat (4) @(negedge clock);
        rst_n = 1'b1;
        chk("rdata_rst", 16'h0000, rdata);
        foreach (rows[i]) begin
            acc(1'b0, rows[i].dev, rows[i].adr, 16'h0000);
            chk("rdata", rows[i].exp, rdata);
        end
        acc(1'b1, 5'h01, 16'h0008, 16'h0000);
        acc(1'b1, 5'h01, 16'h000B, 16'hFFFF);
        acc(1'b0, 5'h01, 16'h0008, 16'h0000);
        chk("stat2_wr", 16'h8301, rdata);
        acc(1'b0, 5'h01, 16'h000B, 16'h0000);
        chk("extab_wr", 16'h0800, rdata);
        chk("tx_on", 16'h0001, {15'h0000, tx_out});
        acc(1'b1, 5'h01, 16'h0009, 16'hFFFF);
        chk("off", 16'h0001, {15'h0000, off});
        chk("tx_gated", 16'h0000, {15'h0000, tx_out});
        acc(1'b0, 5'h01, 16'h0009, 16'h0000);
        chk("txdis_rd", 16'h0001, rdata);
        acc(1'b1, 5'h02, 16'h0009, 16'h0000);
        chk("off_dev2", 16'h0001, {15'h0000, off});
        // clearing the gate lets the line follow the data again
        acc(1'b1, 5'h01, 16'h0009, 16'hFFFE);
        chk("off_clr", 16'h0000, {15'h0000, off});
        chk("tx_follow1", 16'h0001, {15'h0000, tx_out});
        tx_in = 1'b0;
        @(negedge clock);
        chk("tx_follow0", 16'h0000, {15'h0000, tx_out});
        chk("ack_pulse", 16'h0000, {15'h0000, ack});
        tx_in = 1'b1;
        // medium type only applies with autoneg off and forced on
        acc(1'b1, 5'h01, 16'h0007, 16'h003D);
        chk("type_an", {9'h000, an_type}, {9'h000, act_type});
        an_en = 1'b0;
        @(negedge clock);
        chk("type_nf", {9'h000, an_type}, {9'h000, act_type});
        forced = 1'b1;
        @(negedge clock);
        chk("type_forced", {9'h000, PMSR_TYPE_RESET}, {9'h000, act_type});
        an_en = 1'b1;
        @(negedge clock);
        chk("type_an_frc", {9'h000, an_type}, {9'h000, act_type});
        // reset in mid-run clears the gate, the answer and the read data
        @(negedge clock);
        rst_n = 1'b0;
        @(negedge clock);
        rst_n = 1'b1;
        chk("off_rst", 16'h0000, {15'h0000, off});
        chk("rdata_rst2", 16'h0000, rdata);
        chk("ack_rst", 16'h0000, {15'h0000, ack});
        acc(1'b0, 5'h01, 16'h0007, 16'h0000);
        chk("type_rst", {9'h000, PMSR_TYPE_RESET}, rdata);
        test_done();
    end

endmodule : pmsr_regs_tb

// ===== pmsr_ro_word.sv
// pmsr_ro_word: one constant read-only register word.
// assumes: selected by the bank decode; writes are discarded in the bank and never reach this word.
`timescale 1ns/1ps
module pmsr_ro_word
    import pmsr_pkg::*;
#(
    parameter logic [15:0] VALUE = 16'h0000
) (
    // select
    input  wire logic        sel,
    // read data, zero when not selected
    output logic [15:0]      rdata
);

    // constant value; no storage, writes cannot disturb it
    assign rdata = sel ? VALUE : 16'h0000;

endmodule : pmsr_ro_word
